// file: asbt_defines.svh
// timing and geometry constants for the async sram host controller
`ifndef ASBT_DEFINES_SVH
`define ASBT_DEFINES_SVH

`define ASBT_CLK_PERIOD_PS       4000
`define ASBT_ADDR_W              18
`define ASBT_DATA_W              16
`define ASBT_LANE_W              8
// times in picoseconds except the supply wait in microseconds, figures as printed
`define ASBT_SUPPLY_TO_FIRST_US  100
`define ASBT_ADDR_ACCESS_PS      10000
`define ASBT_SELECT_ACCESS_PS    10000
`define ASBT_GATE_ACCESS_PS      5000
`define ASBT_LANE_ACCESS_PS      5000
`define ASBT_ADDR_SETUP_END_PS   7000
`define ASBT_DATA_SETUP_END_PS   5000
`define ASBT_LANE_TO_END_PS      7000
`define ASBT_STROBE_FLOAT_PS     5000
`define ASBT_STANDBY_ENTRY_PS    10000
// cycle counts: least times round up
`define ASBT_CYC_UP(t)           (((t) + `ASBT_CLK_PERIOD_PS - 1) / `ASBT_CLK_PERIOD_PS)
`define ASBT_POWER_CYCLES        ((`ASBT_SUPPLY_TO_FIRST_US * 1000000 + `ASBT_CLK_PERIOD_PS - 1) / `ASBT_CLK_PERIOD_PS)
`define ASBT_CNT_W               16
`define ASBT_SYNC_STAGES         2
`define ASBT_ALL_ONES_LANES      2'h3

`endif

// file: asbt_pkg.sv
// types shared by the async sram host controller
package asbt_pkg;
    typedef struct packed {
        logic        write;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic [1:0]  lanes_n;
    } asbt_req_type;

    typedef struct packed {
        logic        select_n;
        logic        gate_n;
        logic        write_strobe_n;
        logic        low_lane_select_n;
        logic        high_lane_select_n;
        logic [17:0] addr;
    } asbt_pins_type;

    typedef enum logic [2:0] {
        ASBT_POWER_WAIT,
        ASBT_IDLE,
        ASBT_READ,
        ASBT_WRITE_SETUP,
        ASBT_WRITE,
        ASBT_WRITE_END,
        ASBT_RECOVER
    } asbt_state_type;
endpackage

// file: asbt_counter.sv
// down counter whose done stays high once a loaded count expires, until the next load
`timescale 1ns/10ps
module asbt_counter
    import asbt_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    // status
    output logic                  done
);
    logic [WIDTH-1:0] count_reg;

    // load wins over counting so a new wait never inherits an old one
    always_ff @(posedge clock)
    begin
        if (srst)
            count_reg <= '0;
        else if (load)
            count_reg <= value;
        else if (count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    assign done = (count_reg == '0) && !load;
endmodule

// file: asbt_sync.sv
// two flip-flop synchroniser for the sram data pins
`timescale 1ns/10ps
module asbt_sync
    import asbt_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // pins and result
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// file: asbt_host.sv
// host controller driving a 256k x 16 asynchronous static memory
//
// Functional notes
// - wait 100 us after power before the first access
// - address stable at least 7 ns before write end
// - address stable at write start and held to write end
// - write data presented at least 5 ns before write end
// - write data held at least 0 ns after write end
// - setup and hold measured from the signal ending the write
// - lane selects asserted at least 7 ns before write end
// - strobe write with gate low lasts float time plus data setup
// - write strobe stays high for the whole read cycle
// - address valid no later than select falling for reads
`timescale 1ns/10ps
`include "asbt_defines.svh"
module asbt_host
    import asbt_pkg::*;
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // user request
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire asbt_req_type            req,
    // user answer
    output logic                         rsp_valid,
    output logic [`ASBT_DATA_W-1:0]      rsp_rdata,
    output logic                         power_ready,
    // sram control pins
    output asbt_pins_type                pins,
    // sram data pins, enable low while the host drives
    input  wire logic [`ASBT_DATA_W-1:0] data_in,
    output logic [`ASBT_DATA_W-1:0]      data_out,
    output logic                         data_oe_n
);
    localparam int READ_CYC  = `ASBT_CYC_UP(`ASBT_ADDR_ACCESS_PS) + `ASBT_SYNC_STAGES;
    localparam int SETUP_CYC = `ASBT_CYC_UP(`ASBT_ADDR_SETUP_END_PS);
    localparam int DATA_CYC  = `ASBT_CYC_UP(`ASBT_STROBE_FLOAT_PS)
                             + `ASBT_CYC_UP(`ASBT_DATA_SETUP_END_PS);
    localparam int WRITE_CYC = (SETUP_CYC > DATA_CYC) ? SETUP_CYC : DATA_CYC;
    localparam int POWER_CYC = `ASBT_POWER_CYCLES;

    asbt_state_type            state_reg;
    asbt_state_type            state_next;
    asbt_req_type              op_reg;
    logic [`ASBT_CNT_W-1:0]    wait_value;
    logic                      wait_load;
    logic                      wait_done;
    logic [`ASBT_DATA_W-1:0]   data_sync;
    logic                      power_reg;
    logic                      power_loaded_reg;
    asbt_req_type              cur_op;

    // request in flight: live only while idle, then the captured copy
    assign cur_op = (state_reg == ASBT_IDLE) ? req : op_reg;

    // read data: mask off an unselected lane
    function automatic logic [`ASBT_DATA_W-1:0] lane_mask(input logic [1:0] lanes_n,
                                                        input logic [15:0] d);
        lane_mask = {lanes_n[1] ? `ASBT_LANE_W'h00 : d[15:8],
                     lanes_n[0] ? `ASBT_LANE_W'h00 : d[7:0]};
    endfunction

    asbt_counter #(.WIDTH(`ASBT_CNT_W)) u_wait (
        .clock (clock),
        .srst  (srst),
        .load  (wait_load),
        .value (wait_value),
        .done  (wait_done)
    );

    // pins cross into our domain through two flops before capture
    asbt_sync #(.WIDTH(`ASBT_DATA_W)) u_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in (data_in),
        .sync_out (data_sync)
    );

    // next state and counter loads
    always_comb
    begin
        state_next = state_reg;
        wait_load  = 1'b0;
        wait_value = '0;
        unique case (state_reg)
            ASBT_POWER_WAIT:
            begin
                // long wait loaded once, on the first cycle out of reset
                if (!power_loaded_reg)
                begin
                    wait_load  = 1'b1;
                    wait_value = POWER_CYC[`ASBT_CNT_W-1:0];
                end
                if (wait_done && power_reg)
                    state_next = ASBT_IDLE;
            end
            ASBT_IDLE:
                if (req_valid)
                begin
                    wait_load = 1'b1;
                    if (req.write)
                    begin
                        state_next = ASBT_WRITE_SETUP;
                        wait_value = `ASBT_CNT_W'h0;
                    end
                    else
                    begin
                        // two extra cycles cover the input synchroniser
                        state_next = ASBT_READ;
                        wait_value = READ_CYC[`ASBT_CNT_W-1:0];
                    end
                end
            ASBT_READ:
                if (wait_done)
                    state_next = ASBT_RECOVER;
            ASBT_WRITE_SETUP:
            begin
                // address and data settle a full cycle before strobe falls
                state_next = ASBT_WRITE;
                wait_load  = 1'b1;
                wait_value = WRITE_CYC[`ASBT_CNT_W-1:0];
            end
            ASBT_WRITE:
                if (wait_done)
                    state_next = ASBT_WRITE_END;
            ASBT_WRITE_END:
                state_next = ASBT_RECOVER;
            ASBT_RECOVER:
                state_next = ASBT_IDLE;
            default:
                state_next = ASBT_IDLE;
        endcase
    end

    // state register; power wait is loaded once at reset release
    always_ff @(posedge clock)
    begin
        if (srst)
            state_reg <= ASBT_POWER_WAIT;
        else
            state_reg <= state_next;
    end

    // power-up gate: counter loaded on first cycle after reset
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            power_loaded_reg <= 1'b0;
            power_reg        <= 1'b0;
        end
        else
        begin
            power_loaded_reg <= 1'b1;
            power_reg        <= power_loaded_reg;
        end
    end

    // capture the accepted request
    always_ff @(posedge clock)
    begin
        if (srst)
            op_reg <= '0;
        else if (state_reg == ASBT_IDLE && req_valid)
            op_reg <= req;
    end

    // strobes: write strobe rises first so it ends every write
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pins <= '{select_n: 1'b1, gate_n: 1'b1, write_strobe_n: 1'b1,
                      low_lane_select_n: 1'b1, high_lane_select_n: 1'b1,
                      addr: '0};
        end
        else
        begin
            unique case (state_next)
                ASBT_READ:
                begin
                    // address goes out with select, never after it
                    // held from the captured copy so a new user word cannot move it
                    pins.addr               <= cur_op.addr;
                    pins.select_n           <= 1'b0;
                    pins.gate_n             <= 1'b0;
                    pins.write_strobe_n     <= 1'b1;
                    pins.low_lane_select_n  <= cur_op.lanes_n[0];
                    pins.high_lane_select_n <= cur_op.lanes_n[1];
                end
                ASBT_WRITE_SETUP:
                begin
                    // gate high keeps the memory off the bus while we drive
                    pins.addr               <= req.addr;
                    pins.select_n           <= 1'b0;
                    pins.gate_n             <= 1'b1;
                    pins.write_strobe_n     <= 1'b1;
                    pins.low_lane_select_n  <= req.lanes_n[0];
                    pins.high_lane_select_n <= req.lanes_n[1];
                end
                ASBT_WRITE:
                    // no lane selected: nothing to store, strobe stays high
                    pins.write_strobe_n     <= (op_reg.lanes_n == `ASBT_ALL_ONES_LANES);
                ASBT_WRITE_END:
                    pins.write_strobe_n     <= 1'b1;
                default:
                begin
                    // select and lanes released together, address held
                    pins.select_n           <= 1'b1;
                    pins.gate_n             <= 1'b1;
                    pins.write_strobe_n     <= 1'b1;
                    pins.low_lane_select_n  <= 1'b1;
                    pins.high_lane_select_n <= 1'b1;
                end
            endcase
        end
    end

    // data drive: held one cycle past the strobe rise
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            data_out  <= '0;
            data_oe_n <= 1'b1;
        end
        else if (state_next == ASBT_WRITE_SETUP)
        begin
            data_out  <= req.wdata;
            data_oe_n <= 1'b0;
        end
        else if (state_reg == ASBT_WRITE_END)
            data_oe_n <= 1'b1;
    end

    // read answer
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            rsp_valid <= (state_reg == ASBT_READ) && wait_done;
            if ((state_reg == ASBT_READ) && wait_done)
                rsp_rdata <= lane_mask(op_reg.lanes_n, data_sync);
        end
    end

    assign req_ready   = (state_reg == ASBT_IDLE);
    assign power_ready = (state_reg != ASBT_POWER_WAIT);
endmodule

// file: asbt_host_assertions.sv
// port assertions for the sram host controller
`timescale 1ns/10ps
`include "asbt_defines.svh"
module asbt_host_assertions
    import asbt_pkg::*;
#(
    parameter int POWER_CYC = `ASBT_POWER_CYCLES
)
(
    // clock and reset
    input wire logic          clock,
    input wire logic          srst,
    // user side
    input wire logic          req_valid,
    input wire logic          req_ready,
    input wire asbt_req_type  req,
    input wire logic          rsp_valid,
    // sram side
    input wire asbt_pins_type pins,
    input wire logic [15:0]   data_out,
    input wire logic          data_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [15:0] up_reg;
    // cycles since reset, saturating so it never wraps back under the wait
    always_ff @(posedge clock)
    begin
        if (srst)
            up_reg <= 16'h0000;
        else if (up_reg != 16'hffff)
            up_reg <= up_reg + 16'h0001;
    end
    chk_power_wait_idle: assert property (!pins.select_n |-> 32'(up_reg) >= POWER_CYC)
        else $error("memory selected before the power wait ended");
    chk_read_strobe_high: assert property (!pins.select_n && !pins.gate_n |->
        pins.write_strobe_n && data_oe_n) else $error("strobe or drive during read");
    chk_write_qualified: assert property (!pins.write_strobe_n |-> !pins.select_n &&
        !(pins.low_lane_select_n && pins.high_lane_select_n) && !data_oe_n)
        else $error("write strobe without select, lane or data");
    chk_write_long_enough: assert property ($fell(pins.write_strobe_n) |->
        !pins.write_strobe_n[*3]) else $error("write strobe too short");
    chk_addr_before_end: assert property ($rose(pins.write_strobe_n) |->
        pins.addr == $past(pins.addr, 2) && !pins.select_n) else $error("address moved late");
    chk_data_before_end: assert property ($rose(pins.write_strobe_n) |->
        data_out == $past(data_out, 2) && !data_oe_n) else $error("write data late or dropped");
    chk_lanes_before_end: assert property ($rose(pins.write_strobe_n) |->
        pins.low_lane_select_n == $past(pins.low_lane_select_n, 2) &&
        pins.high_lane_select_n == $past(pins.high_lane_select_n, 2))
        else $error("lane selects moved late");
    chk_addr_at_select: assert property ($fell(pins.select_n) |->
        pins.addr == $past(req.addr)) else $error("address not valid at select");
    chk_read_answer: assert property (req_valid && req_ready && !req.write |->
        ##7 rsp_valid) else $error("read answer missing");
    chk_no_contention: assert property (!data_oe_n |-> pins.gate_n)
        else $error("host drives while memory gate open");
endmodule

// file: asbt_sram_model.sv
// behavioural static memory behind the host controller pins
`timescale 1ns/10ps
module asbt_sram_model
    import asbt_pkg::*;
#(
    parameter int ACC_NS = 10
)
(
    // clock only paces the floating pattern
    input wire logic          clock,
    // host pins
    input wire asbt_pins_type pins,
    input wire logic [15:0]   data_out,
    input wire logic          data_oe_n,
    // resolved data wire
    output logic [15:0]       data_in
);
    logic [15:0] mem [0:262143];
    logic [15:0] rd_val;
    logic [15:0] wd;
    logic [17:0] wa;
    logic [1:0]  wl_n;
    logic        rd, rd_lo, rd_hi, lo_d, hi_d, act;
    logic        flt = 1'b0;
    // drive only with select and gate low and strobe high
    assign rd = !pins.select_n && !pins.gate_n && pins.write_strobe_n;
    assign rd_lo = rd && !pins.low_lane_select_n;
    assign rd_hi = rd && !pins.high_lane_select_n;
    // turn-on waits the access time, turn-off is at once
    assign #(ACC_NS) lo_d = rd_lo;
    assign #(ACC_NS) hi_d = rd_hi;
    // old word lingers after an address change
    assign #(ACC_NS) rd_val = mem[pins.addr];
    // released lanes toggle so a stale value is never read as good
    always @(posedge clock)
        flt <= ~flt;
    assign data_in[7:0] = !data_oe_n ? data_out[7:0] : (rd_lo && lo_d) ? rd_val[7:0] : {8{flt}};
    assign data_in[15:8] = !data_oe_n ? data_out[15:8] :
        (rd_hi && hi_d) ? rd_val[15:8] : {8{~flt}};
    // a write lasts while select, strobe and a lane are all low
    assign act = !pins.select_n && !pins.write_strobe_n &&
        !(pins.low_lane_select_n && pins.high_lane_select_n);
    always @*
    begin
        if (act)
        begin
            wa = pins.addr;
            wd = data_out;
            wl_n = {pins.high_lane_select_n, pins.low_lane_select_n};
        end
    end
    // commit at the edge that ends the write, selected lanes only
    always @(negedge act)
    begin
        if (!wl_n[0]) mem[wa][7:0] = wd[7:0];
        if (!wl_n[1]) mem[wa][15:8] = wd[15:8];
    end
endmodule

// file: tb_async_sram_bus_timing.sv
// self-checking bench for the sram host controller
`timescale 1ns/10ps
`include "asbt_defines.svh"
module tb_async_sram_bus_timing;
    import asbt_pkg::*;
    logic          clock, srst, req_valid, req_ready, rsp_valid, power_ready, data_oe_n;
    asbt_req_type  req;
    asbt_pins_type pins;
    logic [15:0]   rsp_rdata, data_in, data_out;
    logic [15:0]   ref_mem [int];
    logic [17:0]   pool [8];
    int            mismatches, comparisons, seed, cyc;
    asbt_host u_asbt_host (.clock(clock), .srst(srst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .power_ready(power_ready), .pins(pins), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n));
    asbt_sram_model u_asbt_sram_model (.clock(clock), .pins(pins), .data_out(data_out),
        .data_oe_n(data_oe_n), .data_in(data_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one request held until taken; reads compared with the reference word
    task automatic do_op(input logic w, input logic [17:0] a, input logic [15:0] d,
                         input logic [1:0] l);
        logic [15:0] keep;
        int          n;
        keep = {{8{l[1]}}, {8{l[0]}}};
        @(posedge clock);
        req <= '{write: w, addr: a, wdata: d, lanes_n: l};
        req_valid <= 1'b1;
        n = 0;
        do
            @(negedge clock);
        while (req_ready !== 1'b1 && ++n < 100);
        // a request never taken is a hang
        if (req_ready !== 1'b1)
            mismatches++;
        @(posedge clock);
        req_valid <= 1'b0;
        if (w)
            ref_mem[a] = (ref_mem[a] & keep) | (d & ~keep);
        else
        begin
            n = 0;
            do
                @(negedge clock);
            while (rsp_valid !== 1'b1 && ++n < 30);
            check({15'h0000, rsp_valid}, 16'h0001);
            check(rsp_rdata, ref_mem[a] & ~keep);
        end
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // cut a hang short well past the power wait and all traffic
    initial
    begin
        repeat (40000) @(posedge clock);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        seed = 81;
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        pool[0] = 18'h00000;
        pool[7] = 18'h3ffff;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        cyc = 0;
        while (power_ready !== 1'b1 && cyc < 30000)
        begin
            @(negedge clock);
            cyc++;
        end
        check({15'h0000, power_ready && cyc >= `ASBT_POWER_CYCLES}, 16'h0001);
        // whole words at both ends of the array and between
        foreach (pool[i])
        begin
            if (i > 0 && i < 7)
                pool[i] = 18'($random(seed));
            do_op(1'b1, pool[i], 16'($random(seed)), 2'h0);
            do_op(1'b0, pool[i], 16'h0000, 2'h0);
        end
        // every lane code on writes and on reads
        for (int k = 0; k < 4; k++)
        begin
            do_op(1'b1, pool[k], 16'($random(seed)), 2'(k));
            do_op(1'b0, pool[k], 16'h0000, 2'(3 - k));
        end
        // back-to-back random mix over the written words
        repeat (40)
            do_op(1'($random(seed)), pool[3'($random(seed))], 16'($random(seed)),
                  2'($random(seed)));
        give_verdict();
    end
endmodule
bind asbt_host asbt_host_assertions u_asbt_host_assertions (.clock(clock), .srst(srst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n));
